/* File: qdac_cfg.svh */
// constants of the quad dac update control
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH
`define QDAC_FRAME_BITS 6'h20
`define QDAC_LAST_BIT 6'h1f
`define QDAC_CMD_WR_IN 4'h0
`define QDAC_CMD_UPD_N 4'h1
`define QDAC_CMD_WR_ALL 4'h2
`define QDAC_CMD_WR_UPD 4'h3
`define QDAC_CMD_CLRSEL 4'h5
`define QDAC_CMD_OVR 4'h6
`define QDAC_ADDR_ALL 4'hf
`define QDAC_CLR_ZERO 2'h0
`define QDAC_CLR_MID 2'h1
`define QDAC_CLR_FULL 2'h2
`define QDAC_CLR_NOP 2'h3
`define QDAC_VAL_ZERO 16'h0000
`define QDAC_VAL_MID 16'h8000
`define QDAC_VAL_FULL 16'hffff
`define QDAC_OVR_RST 4'h0
`define QDAC_CLRSEL_RST 2'h0
`define QDAC_SYNC_RST 5'h1b
`define QDAC_SCLK 0
`define QDAC_SYNCN 1
`define QDAC_SDIN 2
`define QDAC_LDACN 3
`define QDAC_CLRN 4
`endif

/* File: qdac_host_model.sv */
// host serial controller model for the frame link
`timescale 1ns/1ns
`default_nettype none
module qdac_host_model
   import qdac_pkg::*;
(
   // serial link
   output var logic sclk,
   output var logic sync_n,
   output var logic sdin
);
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      sdin = 1'b0;
   end
   task automatic send(input qdac_frame_t f, input int n);
      sync_n = 1'b0;
      for (int b = 31; b > 31 - n; b--) begin
         sdin = f[b];
         #200 sclk = 1'b0;
         #200 sclk = 1'b1;
      end
      sync_n = 1'b1;
      sdin = ~sdin;
      #400;
   endtask
endmodule // qdac_host_model
`default_nettype wire

/* File: qdac_pkg.sv */
// types of the quad dac update control
`default_nettype none
package qdac_pkg;
   typedef logic [15:0] qdac_word_t;
   typedef logic [3:0][15:0] qdac_bank_t;
   // one received serial word, first bit at the top
   typedef struct packed {
      logic [3:0] pad;
      logic [3:0] command_field;
      logic [3:0] channel_address_field;
      qdac_word_t data;
      logic [3:0] tail;
   } qdac_frame_t;
endpackage
`default_nettype wire

/* File: qdac_update_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "qdac_cfg.svh"
module qdac_update_ctrl
   import qdac_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // serial link
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdin,
   // strobes
   input wire logic load_strobe_n,
   input wire logic async_clear_n,
   // register contents
   output qdac_bank_t input_code_r,
   output qdac_bank_t dac_code_r,
   output logic [3:0] override_r,
   output logic [1:0] clear_sel_r
);
   logic [4:0] meta_r;
   logic [4:0] pin_r;
   logic [4:0] prev_r;
   logic [31:0] shift_r;
   logic [31:0] shift_nxt;
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic abort_r;
   logic abort_nxt;
   qdac_bank_t input_nxt;
   qdac_bank_t dac_nxt;
   logic [3:0] ovr_nxt;
   logic [1:0] clrsel_nxt;
   logic sclk_fall;
   logic load_strobe_n_fall;
   logic clr_fall;
   logic load_strobe_n_low;
   logic done;
   logic [3:0] mask;
   logic [3:0] upd;
   qdac_frame_t word;

   // channel select from address field
   function automatic logic [3:0] chan_mask(input logic [3:0] a);
      logic [3:0] m;
      m = 4'h0;
      if (a == `QDAC_ADDR_ALL) begin
         m = 4'hf;
      end else if (a[3:2] == 2'h0) begin
         m[a[1:0]] = 1'b1;
      end
      return m;
   endfunction

   // code loaded by a clear
   function automatic qdac_word_t clear_value(input logic [1:0] s);
      qdac_word_t v;
      v = `QDAC_VAL_ZERO;
      if (s == `QDAC_CLR_MID) begin
         v = `QDAC_VAL_MID;
      end else if (s == `QDAC_CLR_FULL) begin
         v = `QDAC_VAL_FULL;
      end
      return v;
   endfunction

   // two-stage synchronisers, then edge history
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_r <= `QDAC_SYNC_RST;
         pin_r <= `QDAC_SYNC_RST;
         prev_r <= `QDAC_SYNC_RST;
      end else begin
         meta_r <= {async_clear_n, load_strobe_n, sdin, sync_n, sclk};
         pin_r <= meta_r;
         prev_r <= pin_r;
      end
   end

   assign sclk_fall = prev_r[`QDAC_SCLK] & ~pin_r[`QDAC_SCLK];
   assign load_strobe_n_fall = prev_r[`QDAC_LDACN] & ~pin_r[`QDAC_LDACN];
   assign clr_fall = prev_r[`QDAC_CLRN] & ~pin_r[`QDAC_CLRN];
   assign load_strobe_n_low = ~pin_r[`QDAC_LDACN];
   assign word = qdac_frame_t'({shift_r[30:0], pin_r[`QDAC_SDIN]});
   assign mask = chan_mask(word.channel_address_field);
   assign done = ~pin_r[`QDAC_SYNCN] & sclk_fall & ~abort_r
      & (cnt_r == `QDAC_LAST_BIT);

   always_comb begin
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      abort_nxt = abort_r;
      input_nxt = input_code_r;
      dac_nxt = dac_code_r;
      ovr_nxt = override_r;
      clrsel_nxt = clear_sel_r;
      upd = 4'h0;
      // frame select high drops partial word
      if (pin_r[`QDAC_SYNCN]) begin
         cnt_nxt = 6'h00;
         abort_nxt = 1'b0;
      end else if (sclk_fall && !abort_r) begin
         // shift msb first, count 32 bits
         shift_nxt = {shift_r[30:0], pin_r[`QDAC_SDIN]};
         cnt_nxt = 6'((cnt_r + 6'h01) & `QDAC_LAST_BIT);
         if (done) begin
            abort_nxt = 1'b1;
         end
      end
      if (done) begin
         unique case (word.command_field)
            `QDAC_CMD_WR_IN: begin
               // update on 32nd edge when strobe low or channel overridden
               upd = mask & (override_r | {4{load_strobe_n_low}});
            end
            `QDAC_CMD_UPD_N: begin
               upd = mask;
            end
            `QDAC_CMD_WR_ALL: begin
               upd = 4'hf;
            end
            `QDAC_CMD_WR_UPD: begin
               upd = mask;
            end
            `QDAC_CMD_CLRSEL: begin
               // select bits in low two bits
               clrsel_nxt = word.tail[1:0];
            end
            `QDAC_CMD_OVR: begin
               // low four bits, d down to a
               ovr_nxt = word.tail;
            end
            default: begin
               upd = 4'h0;
            end
         endcase
         if (word.command_field inside {`QDAC_CMD_WR_IN,
               `QDAC_CMD_WR_ALL, `QDAC_CMD_WR_UPD}) begin
            for (int i = 0; i < 4; i++) begin
               if (mask[i]) begin
                  input_nxt[i] = word.data;
               end
            end
         end
      end
      // channels left to the strobe pin
      if (load_strobe_n_fall) begin
         upd = upd | ~override_r;
      end
      // every channel flagged in upd takes its input code at once
      for (int i = 0; i < 4; i++) begin
         if (upd[i]) begin
            dac_nxt[i] = input_nxt[i];
         end
      end
      // clear loads code unless select is nop, and aborts the frame
      if (clr_fall) begin
         cnt_nxt = 6'h00;
         abort_nxt = 1'b1;
         if (clear_sel_r != `QDAC_CLR_NOP) begin
            input_nxt = {4{clear_value(clear_sel_r)}};
            dac_nxt = {4{clear_value(clear_sel_r)}};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         shift_r <= 32'h0000_0000;
         cnt_r <= 6'h00;
         abort_r <= 1'b0;
         input_code_r <= '0;
         dac_code_r <= '0;
         override_r <= `QDAC_OVR_RST;
         clear_sel_r <= `QDAC_CLRSEL_RST;
      end else begin
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         abort_r <= abort_nxt;
         input_code_r <= input_nxt;
         dac_code_r <= dac_nxt;
         override_r <= ovr_nxt;
         clear_sel_r <= clrsel_nxt;
      end
   end

   a_ovr_reset: assert property (@(posedge clock)
      sys_rst |=> override_r == 4'h0)
      else $error("override not cleared by reset");

   a_ovr_load: assert property (@(posedge clock)
      disable iff (sys_rst)
      done && word.command_field == `QDAC_CMD_OVR
      |=> override_r == $past(word.tail))
      else $error("override not loaded");

   a_clrsel_load: assert property (@(posedge clock)
      disable iff (sys_rst)
      done && word.command_field == `QDAC_CMD_CLRSEL
      |=> clear_sel_r == $past(word.tail[1:0]))
      else $error("clear select not loaded");

   a_sync_update: assert property (@(posedge clock)
      disable iff (sys_rst)
      done && !clr_fall && word.command_field == `QDAC_CMD_WR_IN
      && mask[0] && (override_r[0] || load_strobe_n_low)
      |=> dac_code_r[0] == $past(word.data))
      else $error("channel a not updated on last edge");

   a_async_hold: assert property (@(posedge clock)
      disable iff (sys_rst)
      done && !clr_fall && !load_strobe_n_fall && !load_strobe_n_low
      && word.command_field == `QDAC_CMD_WR_IN && !override_r[0]
      |=> $stable(dac_code_r[0]))
      else $error("channel a updated without strobe");

   a_strobe_fall: assert property (@(posedge clock)
      disable iff (sys_rst)
      load_strobe_n_fall && !clr_fall && !done && !override_r[1]
      |=> dac_code_r[1] == $past(input_code_r[1]))
      else $error("strobe fall did not update channel b");

   a_sw_strobe: assert property (@(posedge clock)
      disable iff (sys_rst)
      done && !clr_fall && word.command_field == `QDAC_CMD_WR_ALL
      |=> dac_code_r == input_code_r)
      else $error("software strobe missed a channel");

   a_frame_abort: assert property (@(posedge clock)
      disable iff (sys_rst)
      pin_r[`QDAC_SYNCN] && !load_strobe_n_fall && !clr_fall
      |=> cnt_r == 6'h00 && $stable(dac_code_r))
      else $error("early frame end changed state");

   a_clear_mid: assert property (@(posedge clock)
      disable iff (sys_rst)
      clr_fall && clear_sel_r == `QDAC_CLR_MID
      |=> dac_code_r[2] == 16'h8000 && input_code_r[2] == 16'h8000
      ##1 cnt_r == 6'h00)
      else $error("clear did not load midscale");

   a_addr_all: assert property (@(posedge clock)
      disable iff (sys_rst)
      done && !clr_fall && word.command_field == `QDAC_CMD_WR_UPD
      && word.channel_address_field == `QDAC_ADDR_ALL
      |=> dac_code_r[3] == $past(word.data))
      else $error("all-channel address missed channel d");

   a_bit_count: assert property (@(posedge clock)
      disable iff (sys_rst)
      sclk_fall && !pin_r[`QDAC_SYNCN] && !abort_r && !clr_fall
      |=> cnt_r == 6'(($past(cnt_r) + 6'h01) & 6'h1f))
      else $error("bit count wrong");
endmodule // qdac_update_ctrl
`default_nettype wire

/* File: quad_dac_update_control_tb_top.sv */
// testbench for the quad dac update control
`timescale 1ns/1ns
`default_nettype none
module quad_dac_update_control_tb_top;
   import qdac_pkg::*;
   typedef struct packed {
      qdac_bank_t ins;
      qdac_bank_t dac;
      logic [3:0] ovr;
      logic [1:0] sel;
   } qdac_snap_t;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic load_strobe_n = 1'b1;
   logic async_clear_n = 1'b1;
   wire logic sclk;
   wire logic sync_n;
   wire logic sdin;
   qdac_bank_t input_code_r;
   qdac_bank_t dac_code_r;
   logic [3:0] override_r;
   logic [1:0] clear_sel_r;
   qdac_snap_t exp_s;
   qdac_snap_t e;
   qdac_snap_t q[$];
   int fails = 0;
   int comparisons = 0;
   int i;
   integer seed = 32'hf098;
   event chk;
   initial forever #25 clock = ~clock;
   qdac_update_ctrl DUT(.clock(clock), .sys_rst(sys_rst), .sclk(sclk),
      .sync_n(sync_n), .sdin(sdin), .load_strobe_n(load_strobe_n),
      .async_clear_n(async_clear_n), .input_code_r(input_code_r),
      .dac_code_r(dac_code_r), .override_r(override_r),
      .clear_sel_r(clear_sel_r));
   qdac_host_model host(.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
   task automatic compare(input logic [63:0] seen, input logic [63:0] want);
      comparisons++;
      if (seen !== want) begin
         fails++;
         $display("mismatch at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic summarize();
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic note();
      q.push_back(exp_s);
      -> chk;
   endtask
   task automatic op(input logic [3:0] cmd, input logic [3:0] adr,
         input logic [3:0] t, input int n);
      qdac_frame_t f;
      f = qdac_frame_t'($random(seed));
      f.command_field = cmd;
      f.channel_address_field = adr;
      f.tail = t;
      if (n == 32) begin
         for (int c = 0; c < 4; c++) begin
            if (adr == c[3:0] || adr == 4'hf) begin
               if (cmd inside {4'h0, 4'h2, 4'h3}) exp_s.ins[c] = f.data;
               if (cmd == 4'h3 || (cmd == 4'h0 &&
                     (exp_s.ovr[c] || !load_strobe_n))) exp_s.dac[c] = f.data;
               if (cmd == 4'h1) exp_s.dac[c] = exp_s.ins[c];
            end
         end
         if (cmd == 4'h2) exp_s.dac = exp_s.ins;
         if (cmd == 4'h5) exp_s.sel = t[1:0];
         if (cmd == 4'h6) exp_s.ovr = t;
      end
      @(posedge clock);
      #2;
      host.send(f, n);
      note();
   endtask
   task automatic strobe(input logic lv);
      @(posedge clock);
      #2;
      for (int c = 0; c < 4; c++)
         if (!lv && load_strobe_n && !exp_s.ovr[c])
            exp_s.dac[c] = exp_s.ins[c];
      load_strobe_n = lv;
      repeat (8) @(posedge clock);
   endtask
   task automatic clear_pulse();
      qdac_word_t v;
      v = exp_s.sel[1] ? 16'hffff : {exp_s.sel[0], 15'h0};
      @(posedge clock);
      #2 async_clear_n = 1'b0;
      if (exp_s.sel != 2'h3) begin
         exp_s.ins = {4{v}};
         exp_s.dac = {4{v}};
      end
      repeat (8) @(posedge clock);
      #2 async_clear_n = 1'b1;
      repeat (4) @(posedge clock);
      note();
   endtask
   // clear falls part way through a write to all channels
   task automatic clear_in_frame();
      qdac_frame_t f;
      qdac_word_t v;
      f = qdac_frame_t'($random(seed));
      f.command_field = 4'h3;
      f.channel_address_field = 4'hf;
      v = exp_s.sel[1] ? 16'hffff : {exp_s.sel[0], 15'h0};
      if (exp_s.sel != 2'h3) begin
         exp_s.ins = {4{v}};
         exp_s.dac = {4{v}};
      end
      @(posedge clock);
      #2;
      fork
         host.send(f, 32);
         begin
            repeat (160) @(posedge clock);
            #2 async_clear_n = 1'b0;
            repeat (8) @(posedge clock);
            #2 async_clear_n = 1'b1;
         end
      join
      note();
   endtask
   initial forever begin
      @(chk);
      e = q.pop_front();
      compare(input_code_r, e.ins);
      compare(dac_code_r, e.dac);
      compare(override_r, e.ovr);
      compare(clear_sel_r, e.sel);
   end
   initial begin
      #1000000;
      fails++;
      summarize();
   end
   initial begin
      repeat (2) @(posedge clock);
      #2 sys_rst = 1'b0;
      exp_s = '0;
      repeat (3) @(posedge clock);
      note();
      op(4'h0, 4'h0, 4'h0, 32);
      strobe(1'b0);
      strobe(1'b1);
      note();
      op(4'h3, 4'h1, 4'h0, 32);
      op(4'h0, 4'h7, 4'h0, 32);
      op(4'h1, 4'hf, 4'h0, 32);
      op(4'h0, 4'h3, 4'h0, 32);
      op(4'h2, 4'h2, 4'h0, 32);
      strobe(1'b0);
      op(4'h0, 4'hf, 4'h0, 32);
      strobe(1'b1);
      op(4'h6, 4'h5, 4'($random(seed)), 32);
      op(4'h0, 4'hf, 4'h0, 32);
      strobe(1'b0);
      strobe(1'b1);
      note();
      op(4'h0, 4'hf, 4'h0, 20);
      op(4'h6, 4'h0, 4'hf, 31);
      for (i = 0; i < 4; i++) begin
         op(4'h5, 4'h9, {2'h3, i[1:0]}, 32);
         op(4'h0, 4'hf, 4'h0, 32);
         clear_pulse();
      end
      // clear aborts a frame in progress
      op(4'h5, 4'h0, 4'h2, 32);
      clear_in_frame();
      op(4'h5, 4'h0, 4'h1, 32);
      op(4'h0, 4'hf, 4'h0, 32);
      clear_in_frame();
      #10;
      summarize();
   end
endmodule // quad_dac_update_control_tb_top
`default_nettype wire
